//--- src/pwg_top.v
// Pulse-width generator with APB register access.
// Assumes a single 10 MHz reference clock and an APB master in the same domain.
`timescale 1ns/1ps
`include "pwg_map.vh"

module pwg_top #(
	parameter SLOW_DIV = `PWG_REF_HZ / `PWG_SLOW_HZ
) (
	// Clock and reset
	input wire REF_CLK,
	input wire RST_N,
	// APB slave
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [11:0] PADDR,
	input wire [31:0] PWDATA,
	input wire [3:0] PSTRB,
	output reg [31:0] PRDATA,
	output reg PREADY,
	output reg PSLVERR,
	// Drive output
	output reg PWM_OUT
);
	localparam [1:0] ST_OFF = 2'b01;
	localparam [1:0] ST_ON = 2'b10;

	reg [6:0] cfg_q;
	reg [15:0] high_q;
	reg [15:0] low_q;
	reg [15:0] high_hold_q;
	reg [15:0] low_hold_q;
	reg [3:0] fresh_q;
	reg [15:0] cnt_q;
	reg [1:0] st_q;
	wire tick;
	wire en;
	wire inv;
	wire setup;
	wire wr;
	wire full_on;
	wire full_off;
	wire pend;
	wire apply;
	wire [15:0] high_nx;
	wire [15:0] low_nx;
	wire off_nx;
	wire sel_high;
	wire sel_low;
	wire sel_cfg;
	wire sel_stat;
	wire hit;
	reg [31:0] rd_d;

	assign en = cfg_q[`PWG_CFG_EN];
	assign inv = cfg_q[`PWG_CFG_INV];
	assign setup = PSEL & ~PENABLE;
	assign wr = PSEL & PENABLE & PWRITE & PREADY;
	assign sel_high = (PADDR[11:2] == 10'h000) && (PADDR[3:0] == `PWG_OFS_HIGH);
	assign sel_low = (PADDR[11:4] == 8'h00) && (PADDR[3:0] == `PWG_OFS_LOW);
	assign sel_cfg = (PADDR[11:4] == 8'h00) && (PADDR[3:0] == `PWG_OFS_CFG);
	assign sel_stat = (PADDR[11:4] == 8'h00) && (PADDR[3:0] == `PWG_OFS_STAT);
	assign hit = sel_high | sel_low | sel_cfg | sel_stat;

	// ------------------------------------------------------------
	// Output state decode
	// ------------------------------------------------------------
	assign full_on = (low_q == `PWG_ZERO16);
	assign full_off = (high_q == `PWG_ZERO16) && !full_on;
	assign pend = &fresh_q;
	// Holding copies move when all four bytes are new, at OFF end or at once in full-on
	assign apply = pend && (full_on || (st_q == ST_OFF && cnt_q == `PWG_ZERO16 && tick));
	// New counts take effect with the ON load that ends the OFF phase, not one period late
	assign high_nx = apply ? high_hold_q : high_q;
	assign low_nx = apply ? low_hold_q : low_q;
	assign off_nx = (high_nx == `PWG_ZERO16) && (low_nx != `PWG_ZERO16);

	// ------------------------------------------------------------
	// Rate generator
	// ------------------------------------------------------------
	pwg_tick #(
		.SLOW_DIV(SLOW_DIV)
	) u_tick (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.run(en),
		.clk_sel(cfg_q[`PWG_CFG_CLKSEL]),
		.pre_div(cfg_q[`PWG_CFG_DIV_HI:`PWG_CFG_DIV_LO]),
		.tick(tick)
	);

	// ------------------------------------------------------------
	// APB handshake: no wait states, unmapped addresses flag an error
	// ------------------------------------------------------------
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h00000000;
		end else begin
			PREADY <= setup;
			PSLVERR <= setup & ~hit;
			PRDATA <= setup ? rd_d : 32'h00000000;
		end
	end

	// Read mux; counts show the active copies, not the holding ones
	always @* begin
		rd_d = 32'h00000000;
		if (!PWRITE) begin
			if (sel_high) begin
				rd_d = {16'h0000, high_q};
			end else if (sel_low) begin
				rd_d = {16'h0000, low_q};
			end else if (sel_cfg) begin
				rd_d = {25'h0000000, cfg_q};
			end else if (sel_stat) begin
				rd_d[`PWG_STAT_ON] = (st_q == ST_ON);
				rd_d[`PWG_STAT_PEND] = pend;
			end
		end
	end

	// ------------------------------------------------------------
	// Configuration register, byte lane 0 only
	// ------------------------------------------------------------
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cfg_q <= `PWG_RST_CFG;
		end else if (wr && sel_cfg && PSTRB[0]) begin
			cfg_q <= PWDATA[`PWG_CFG_W-1:0];
		end
	end

	// Holding copies and per-byte freshness; unaffected by enable
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			high_hold_q <= `PWG_RST_HIGH;
			low_hold_q <= `PWG_RST_LOW;
			fresh_q <= 4'h0;
		end else begin
			if (apply) begin
				fresh_q <= 4'h0;
			end
			if (wr && sel_high) begin
				if (PSTRB[0]) begin
					high_hold_q[7:0] <= PWDATA[7:0];
					fresh_q[0] <= 1'b1;
				end
				if (PSTRB[1]) begin
					high_hold_q[15:8] <= PWDATA[15:8];
					fresh_q[1] <= 1'b1;
				end
			end
			if (wr && sel_low) begin
				if (PSTRB[0]) begin
					low_hold_q[7:0] <= PWDATA[7:0];
					fresh_q[2] <= 1'b1;
				end
				if (PSTRB[1]) begin
					low_hold_q[15:8] <= PWDATA[15:8];
					fresh_q[3] <= 1'b1;
				end
			end
		end
	end

	// Active counts loaded only from the holding copies
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			high_q <= `PWG_RST_HIGH;
			low_q <= `PWG_RST_LOW;
		end else if (apply) begin
			high_q <= high_hold_q;
			low_q <= low_hold_q;
		end
	end

	// ------------------------------------------------------------
	// On/off sequencer with 16-bit down-counter
	// ------------------------------------------------------------
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_q <= ST_OFF;
			cnt_q <= `PWG_ZERO16;
		end else if (!en) begin
			st_q <= ST_OFF;
			cnt_q <= `PWG_ZERO16;
		end else if (tick) begin
			case (st_q)
				ST_OFF: begin
					if (cnt_q != `PWG_ZERO16) begin
						cnt_q <= cnt_q - 16'h0001;
					end else if (!off_nx) begin
						cnt_q <= high_nx;
						st_q <= ST_ON;
					end
				end
				ST_ON: begin
					if (cnt_q != `PWG_ZERO16) begin
						cnt_q <= cnt_q - 16'h0001;
					end else if (!full_on) begin
						cnt_q <= low_q;
						st_q <= ST_OFF;
					end
				end
				default: begin
					st_q <= ST_OFF;
					cnt_q <= `PWG_ZERO16;
				end
			endcase
		end
	end

	// Output level; fixed levels override the sequencer, polarity applied last
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			PWM_OUT <= 1'b0;
		end else if (!en) begin
			PWM_OUT <= inv;
		end else if (full_on) begin
			PWM_OUT <= ~inv;
		end else if (full_off) begin
			PWM_OUT <= inv;
		end else begin
			PWM_OUT <= (st_q == ST_ON) ^ inv;
		end
	end
endmodule // pwg_top

//--- src/pwg_map.vh
// Register map, field layout and reset values of the pulse-width generator.
// Assumes a 32-bit APB slave with word-aligned registers.
`ifndef PWG_MAP_VH
`define PWG_MAP_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define PWG_OFS_HIGH 4'h0
`define PWG_OFS_LOW 4'h4
`define PWG_OFS_CFG 4'h8
`define PWG_OFS_STAT 4'hc

// ------------------------------------------------------------
// Configuration fields
// ------------------------------------------------------------
`define PWG_CFG_EN 0
`define PWG_CFG_CLKSEL 1
`define PWG_CFG_INV 2
`define PWG_CFG_DIV_LO 3
`define PWG_CFG_DIV_HI 6
`define PWG_CFG_W 7

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define PWG_RST_CFG 7'h01
`define PWG_RST_HIGH 16'h0000
`define PWG_RST_LOW 16'hffff
`define PWG_ZERO16 16'h0000

// ------------------------------------------------------------
// Clock rates and status field
// ------------------------------------------------------------
`define PWG_REF_HZ 10000000
`define PWG_SLOW_HZ 90000
`define PWG_STAT_ON 0
`define PWG_STAT_PEND 1

`endif

//--- src/pwg_tick.v
// Rate generator: picks the fast or slow tick and applies the pre-divider.
// Assumes one reference clock; the slow rate is made here as a one-cycle enable.
`timescale 1ns/1ps
`include "pwg_map.vh"

module pwg_tick #(
	parameter SLOW_DIV = `PWG_REF_HZ / `PWG_SLOW_HZ
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Control
	input wire run,
	input wire clk_sel,
	input wire [3:0] pre_div,
	// Counter tick
	output reg tick
);
	// The slow divider is 8 bits wide, so SLOW_DIV must stay at or below 256
	localparam [31:0] SLOW_DIV_W = SLOW_DIV;
	localparam [7:0] SLOW_LAST = SLOW_DIV_W[7:0] - 8'h01;

	reg [7:0] slow_q;
	reg [3:0] div_q;
	wire slow_en;
	wire src_en;

	// ------------------------------------------------------------
	// Slow source enable; stopped while disabled to save power
	// ------------------------------------------------------------
	assign slow_en = (slow_q == SLOW_LAST);
	assign src_en = clk_sel ? slow_en : 1'b1;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slow_q <= 8'h00;
		end else if (!run || slow_en) begin
			slow_q <= 8'h00;
		end else begin
			slow_q <= slow_q + 8'h01;
		end
	end

	// Pre-divider: value N gives one tick per N+1 source pulses, 0 passes through
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= 4'h0;
			tick <= 1'b0;
		end else if (!run) begin
			div_q <= 4'h0;
			tick <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (src_en) begin
				if (div_q >= pre_div) begin
					div_q <= 4'h0;
					tick <= 1'b1;
				end else begin
					div_q <= div_q + 4'h1;
				end
			end
		end
	end
endmodule // pwg_tick

//--- test/pwg_fan_model.sv
// Fan drive stand-in: measures how long the drive pin rests at each level.
// Assumes the pin is sampled on the generator's reference clock.
`timescale 1ns/1ps

module pwg_fan_model (
	// Clock
	input wire clk,
	// Drive pin and last completed run lengths in cycles
	input wire pin,
	output int hi_len,
	output int lo_len
);
	logic last_q;
	int run_q = 0;
	// A fan only sees the average, so run lengths are all it needs
	always @(posedge clk) begin
		last_q <= pin;
		run_q <= (pin != last_q) ? 1 : run_q + 1;
		if (pin != last_q && last_q)
			hi_len <= run_q;
		if (pin != last_q && !last_q)
			lo_len <= run_q;
	end
endmodule // pwg_fan_model

//--- test/pwg_top_sva.sv
// Checker for the pulse-width generator ports.
// Assumes it is bound into pwg_top.
`timescale 1ns/1ps

module pwg_top_sva #(
	parameter SLOW_DIV = 111
) (
	// Clock and reset
	input wire REF_CLK,
	input wire RST_N,
	// APB
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [11:0] PADDR,
	input wire [31:0] PWDATA,
	input wire [3:0] PSTRB,
	input wire [31:0] PRDATA,
	input wire PREADY,
	input wire PSLVERR,
	// Drive
	input wire PWM_OUT
);
	logic [6:0] cfg_q;
	logic [15:0] age_q, run_q;
	logic prev_q;
	wire done = PSEL && PENABLE && PREADY;
	wire cfg_wr = done && PWRITE && PADDR == 12'h8;
	wire flip = PWM_OUT != prev_q;
	wire [15:0] unit = {12'h0, cfg_q[6:3]} + 16'h1;
	// Only runs that began well after a config change have a clean tick phase
	wire settled = cfg_q[0] && run_q + 16'd64 < age_q;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	// Config shadow, its age, and the length of the run that just ended
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cfg_q <= 7'h01;
			age_q <= 16'h0;
			run_q <= 16'h0;
			prev_q <= 1'b0;
		end else begin
			if (cfg_wr && PSTRB[0])
				cfg_q <= PWDATA[6:0];
			age_q <= cfg_wr ? 16'h0 : age_q + {15'h0, ~&age_q}; // Saturates
			run_q <= flip ? 16'h1 : run_q + 16'h1;
			prev_q <= PWM_OUT;
		end
	end
	a_ready_off: assert property (PSEL && !PENABLE && !cfg_q[0] |=> PREADY ##1 !PREADY)
		else $error("no answer while disabled");
	a_idle_level: assert property (!cfg_q[0] && age_q > 16'd3 |-> PWM_OUT == cfg_q[2])
		else $error("wrong idle level");
	a_gated_quiet: assert property (!cfg_q[0] && age_q > 16'd3 |=> $stable(PWM_OUT))
		else $error("output moved while disabled");
	a_cfg_back: assert property (done && !PWRITE && PADDR == 12'h8 |-> PRDATA == {25'h0, cfg_q})
		else $error("config readback wrong");
	a_count_width: assert property (done && !PWRITE && PADDR[11:3] == 9'h0 |-> PRDATA[31:16] == 16'h0)
		else $error("count wider than 16 bits");
	a_div_runs: assert property (flip && settled && !cfg_q[1] |-> run_q % unit == 16'h0)
		else $error("run not a whole number of ticks");
	a_slow_runs: assert property (flip && settled && cfg_q[1] |-> run_q % (unit * SLOW_DIV) == 0)
		else $error("run not a whole number of slow ticks");
	a_full_on: assert property (done && !PWRITE && PADDR == 12'h4 && PRDATA[15:0] == 16'h0
		&& cfg_q[0] && age_q > 16'd3 |=> PWM_OUT == !cfg_q[2])
		else $error("not held on with zero low count");
	c_slow: cover property (flip && cfg_q[1]);
	c_off: cover property (!cfg_q[0] && age_q > 16'd3);
	c_err: cover property (done && PSLVERR);
endmodule // pwg_top_sva

bind pwg_top pwg_top_sva #(.SLOW_DIV(SLOW_DIV)) u_sva (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .PWM_OUT(PWM_OUT));

//--- test/testbench.sv
// Self-checking bench for the pulse-width generator over APB.
// Assumes pwg_top, its checker and the fan model are compiled first.
`timescale 1ns/1ps

module testbench;
	typedef struct packed {logic [11:0] a; logic w; logic [31:0] d; logic [31:0] x; logic e;} pwg_row_t;
	logic REF_CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic [11:0] PADDR = 12'h0;
	logic [31:0] PWDATA = 32'h0, r;
	logic [3:0] PSTRB = 4'hf;
	logic e;
	wire [31:0] PRDATA;
	wire PREADY, PSLVERR, PWM_OUT;
	int fails = 0, cmp_count = 0, hi_len, lo_len, h0, l0;
	// Reset values, an unmapped place, reserved bits, then counts parked while disabled
	pwg_row_t rows [11] = '{'{12'h8, 0, 0, 32'h1, 0}, '{12'h0, 0, 0, 0, 0}, '{12'h4, 0, 0, 32'hffff, 0},
		'{12'h10, 0, 0, 0, 1}, '{12'h10, 1, 32'hffffffff, 0, 1}, '{12'h8, 1, 32'hffffff80, 0, 0},
		'{12'h8, 0, 0, 0, 0}, '{12'h0, 1, 32'h2, 0, 0}, '{12'h4, 1, 32'h5, 0, 0},
		'{12'h0, 0, 0, 0, 0}, '{12'h4, 0, 0, 32'hffff, 0}};

	pwg_top #(.SLOW_DIV(4)) dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .PWM_OUT(PWM_OUT));
	pwg_fan_model fan (.clk(REF_CLK), .pin(PWM_OUT), .hi_len(hi_len), .lo_len(lo_len));

	always #50 REF_CLK = ~REF_CLK;

	task chk(input [31:0] got, input [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One transfer, then an idle edge so the next call never re-drives in the same step
	task apb(input [11:0] a, input w, input [31:0] d, output [31:0] rv, output ev);
		PSEL <= 1'b1;
		PADDR <= a;
		PWRITE <= w;
		PWDATA <= d;
		@(posedge REF_CLK);
		PENABLE <= 1'b1;
		@(posedge REF_CLK);
		// No wait-state count is assumed; only the watchdog ends a hung transfer
		while (PREADY !== 1'b1) begin
			@(posedge REF_CLK);
		end
		rv = PRDATA;
		ev = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge REF_CLK);
	endtask
	task wr(input [11:0] a, input [31:0] d);
		apb(a, 1'b1, d, r, e);
	endtask
	task rd(input [11:0] a, input [31:0] x);
		apb(a, 1'b0, 32'h0, r, e);
		chk(r, x);
	endtask
	task finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Watchdog: the sequence needs under a thousand cycles
	initial begin
		#400000;
		fails++;
		finish_test;
	end

	initial begin
		repeat (6) @(posedge REF_CLK);
		RST_N <= 1'b1;
		@(posedge REF_CLK);
		for (int i = 0; i < 11; i++) begin
			apb(rows[i].a, rows[i].w, rows[i].d, r, e);
			if (!rows[i].w) chk(r, rows[i].x);
			chk({31'h0, e}, {31'h0, rows[i].e});
		end
		$display("register rows done");
		wr(12'h8, 32'h4);
		repeat (4) @(posedge REF_CLK);
		chk(PWM_OUT, 1'b1);
		rd(12'h0, 32'h0);
		wr(12'h8, 32'h1);
		repeat (60) @(posedge REF_CLK);
		h0 = hi_len;
		l0 = lo_len;
		chk(l0 - h0, 3);
		chk(h0, 3);
		chk(l0, 6);
		rd(12'h0, 32'h2);
		wr(12'h8, 32'h11);
		repeat (150) @(posedge REF_CLK);
		chk(hi_len, 3 * h0);
		chk(lo_len, 3 * l0);
		wr(12'h8, 32'h3);
		repeat (200) @(posedge REF_CLK);
		chk(hi_len, 4 * h0);
		chk(lo_len, 4 * l0);
		$display("rate tests done");
		wr(12'h8, 32'h1);
		wr(12'h4, 32'h0);
		wr(12'h0, 32'h2);
		repeat (40) @(posedge REF_CLK);
		chk(PWM_OUT, 1'b1);
		rd(12'h4, 32'h0);
		wr(12'h0, 32'h7);
		wr(12'h4, 32'h3);
		rd(12'h0, 32'h7);
		wr(12'h0, 32'h0);
		wr(12'h4, 32'h3);
		repeat (60) @(posedge REF_CLK);
		chk(PWM_OUT, 1'b0);
		// Byte lane 0 alone never completes the pair, so nothing may move
		PSTRB <= 4'h1;
		wr(12'h0, 32'h4);
		wr(12'h4, 32'h0);
		rd(12'h0, 32'h0);
		rd(12'hc, 32'h0);
		PSTRB <= 4'h2;
		wr(12'h0, 32'h0);
		wr(12'h4, 32'h0);
		PSTRB <= 4'hf;
		rd(12'h0, 32'h4);
		repeat (10) @(posedge REF_CLK);
		chk(PWM_OUT, 1'b1);
		rd(12'hc, 32'h1);
		$display("full on and off done");
		RST_N <= 1'b0;
		repeat (2) @(posedge REF_CLK);
		chk(PWM_OUT, 1'b0);
		RST_N <= 1'b1;
		@(posedge REF_CLK);
		rd(12'h8, 32'h1);
		$display("reset test done");
		finish_test;
	end
endmodule // testbench
